// ==== adc_mode_ctl.sv ====
`timescale 1ns/1ps

// How it works
// - reference stays off while its enable is clear; on, level follows level select
// - quarter ratio: active one quarter, standby three quarters of the time
// - sixteenth ratio: active one sixteenth, standby fifteen sixteenths
// - ratio bit only matters while the duty cycling mode is selected
// - active time is one sequence conversion; standby is a multiple of it
// - duty cycling alternates sequence conversion and standby
// - sequence-plus-idle: convert, go idle, sync falling edge restarts
// - sequence-plus-standby: convert, enter standby, sync falling edge restarts
// - power-down only from standby, otherwise continuous conversion instead
// - idle holds filter and modulator in reset, nothing else changes
// - finished offset calibration switches the mode field to idle
// - select 00: internal oscillator, clock pin not driven
// - select 01: internal oscillator, also driven onto the clock pin
// - select 10: clock pin used directly, partner supplies the base rate
// - select 11: partner supplies double rate, divided by two inside
module adc_mode_ctl #(
  parameter int CONV_TICKS = 16,
  parameter int CAL_TICKS = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire adc_ctl_pkg::reg_req_t req,
  output logic [adc_ctl_pkg::DATA_W-1:0] rd_data,
  input wire logic osc_clk,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  input wire logic sync_n,
  output logic ref_enable,
  output logic reference_level_select,
  output logic modulator_reset,
  output logic converting,
  output logic low_power_hold_state,
  output logic power_down,
  output logic seq_done
);
  import adc_ctl_pkg::*;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TICKS - 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_TICKS - 1);

  // standby length follows the ratio bit; only consulted in duty cycling
  function automatic logic [CNT_W-1:0] low_power_hold_state_last(input cfg_t c);
    int mult;
    mult = c.active_fraction_select ? LOW_POWER_HOLD_STATE_MULT_SIXTEENTH : LOW_POWER_HOLD_STATE_MULT_QUARTER;
    return CNT_W'(CONV_TICKS * mult - 1);
  endfunction

  // codes left undefined are treated like the reserved ones
  function automatic logic mode_ok(input logic [3:0] m);
    return (m <= MODE_CONT) || (m == MODE_DUTY) || (m == MODE_SYNC_IDLE)
        || (m == MODE_SYNC_LOW_POWER_HOLD_STATE);
  endfunction

  logic [1:0] rst_ff;
  logic rst_n;
  state_t q;
  state_t d;
  cfg_t wcfg;
  logic wr_cfg;
  logic osc_rise;
  logic pin_rise;
  logic sync_fall;
  logic tick;
  logic conv_end;
  logic cal_end;
  logic low_power_hold_state_end;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  assign wcfg = cfg_t'(req.wdata);
  assign wr_cfg = req.wr && (req.addr == CFG_ADDR);
  assign osc_rise = osc_clk & ~q.osc_q;
  assign pin_rise = clk_pin_in & ~q.pin_q;
  assign sync_fall = ~sync_n & q.sync_q;

  // main clock tick from the selected source
  always_comb begin
    case (q.cfg.clk_sel)
      CLK_EXT: tick = pin_rise;
      CLK_EXT_DIV2: tick = pin_rise & q.div_q;
      default: tick = osc_rise;
    endcase
  end

  assign conv_end = (q.st == ST_CONV) && tick && (q.cnt == CONV_LAST);
  assign cal_end = (q.st == ST_CAL) && tick && (q.cnt == CAL_LAST);
  assign low_power_hold_state_end = (q.st == ST_LOW_POWER_HOLD_STATE) && (q.cfg.op_mode == MODE_DUTY) && tick
      && (q.cnt == low_power_hold_state_last(q.cfg));

  always_comb begin
    d = q;
    d.osc_q = osc_clk;
    d.pin_q = clk_pin_in;
    d.sync_q = sync_n;
    if (pin_rise) begin
      d.div_q = ~q.div_q;
    end
    if (tick) begin
      d.cnt = q.cnt + 1'b1;
    end

    d.rd_data = '0;
    if (req.rd) begin
      case (req.addr)
        CFG_ADDR: d.rd_data = q.cfg;
        STATUS_ADDR: d.rd_data = DATA_W'(q.st);
        default: d.rd_data = '0;
      endcase
    end

    case (q.st)
      ST_CONV: begin
        if (conv_end) begin
          d.cnt = '0;
          case (q.cfg.op_mode)
            MODE_SYNC_IDLE: d.st = ST_IDLE;
            MODE_DUTY, MODE_SYNC_LOW_POWER_HOLD_STATE, MODE_SINGLE: d.st = ST_LOW_POWER_HOLD_STATE;
            default: d.st = ST_CONV;
          endcase
        end
      end
      ST_CAL: begin
        if (cal_end) begin
          d.st = ST_IDLE;
          d.cfg.op_mode = MODE_IDLE;
          d.cnt = '0;
        end
      end
      ST_LOW_POWER_HOLD_STATE: begin
        if (low_power_hold_state_end || (sync_fall && q.cfg.op_mode == MODE_SYNC_LOW_POWER_HOLD_STATE)) begin
          d.st = ST_CONV;
          d.cnt = '0;
        end
      end
      ST_IDLE: begin
        if (sync_fall && q.cfg.op_mode == MODE_SYNC_IDLE) begin
          d.st = ST_CONV;
          d.cnt = '0;
        end
      end
      ST_PDOWN: d.st = ST_PDOWN;
      default: d.st = ST_IDLE;
    endcase

    // a software write with a valid mode code overrides whatever the sequencer chose this cycle
    if (wr_cfg) begin
      d.cfg.int_ref_en = wcfg.int_ref_en;
      d.cfg.reference_level_select = wcfg.reference_level_select;
      d.cfg.active_fraction_select = wcfg.active_fraction_select;
      d.cfg.clk_sel = wcfg.clk_sel;
      if (mode_ok(wcfg.op_mode)) begin
        d.cfg.op_mode = wcfg.op_mode;
        d.cnt = '0;
        case (wcfg.op_mode)
          MODE_LOW_POWER_HOLD_STATE: d.st = ST_LOW_POWER_HOLD_STATE;
          MODE_IDLE: d.st = ST_IDLE;
          MODE_CAL: d.st = ST_CAL;
          MODE_PDOWN: begin
            if (q.st == ST_LOW_POWER_HOLD_STATE) begin
              d.st = ST_PDOWN;
            end else begin
              d.st = ST_CONV;
              d.cfg.op_mode = MODE_CONT;
            end
          end
          default: d.st = ST_CONV;
        endcase
      end
    end

    d.ref_on = q.cfg.int_ref_en;
    d.ref_lvl = q.cfg.int_ref_en & q.cfg.reference_level_select;
    d.clk_oe = (q.cfg.clk_sel == CLK_INT_OUT);
    d.clk_out = osc_clk & (q.cfg.clk_sel == CLK_INT_OUT);
    d.mod_rst = (q.st == ST_IDLE) || (q.st == ST_LOW_POWER_HOLD_STATE) || (q.st == ST_PDOWN);
    d.conv = (q.st == ST_CONV);
    d.hold = (q.st == ST_LOW_POWER_HOLD_STATE);
    d.pdown = (q.st == ST_PDOWN);
    d.done = conv_end;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign clk_pin_out = q.clk_out;
  assign clk_pin_oe = q.clk_oe;
  assign ref_enable = q.ref_on;
  assign reference_level_select = q.ref_lvl;
  assign modulator_reset = q.mod_rst;
  assign converting = q.conv;
  assign low_power_hold_state = q.hold;
  assign power_down = q.pdown;
  assign seq_done = q.done;

  property p_ref_off;
    @(posedge sys_clk) disable iff (!rst_n)
    !q.cfg.int_ref_en ##1 !q.cfg.int_ref_en |-> !ref_enable && !reference_level_select;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference on while disabled");

  property p_clk_hidden;
    @(posedge sys_clk) disable iff (!rst_n)
    q.cfg.clk_sel == CLK_INT_OFF |=> !clk_pin_oe;
  endproperty
  a_clk_hidden: assert property (p_clk_hidden) else $error("clock pin driven");

  property p_clk_shown;
    @(posedge sys_clk) disable iff (!rst_n)
    q.cfg.clk_sel == CLK_INT_OUT |=> clk_pin_oe && (clk_pin_out == $past(osc_clk));
  endproperty
  a_clk_shown: assert property (p_clk_shown) else $error("oscillator not on pin");

  property p_cal_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    cal_end && !wr_cfg |=> q.st == ST_IDLE && q.cfg.op_mode == MODE_IDLE;
  endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("calibration did not go idle");

  property p_pdown_guard;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cfg && wcfg.op_mode == MODE_PDOWN && q.st != ST_LOW_POWER_HOLD_STATE
      |=> q.st == ST_CONV && q.cfg.op_mode == MODE_CONT ##1 !power_down;
  endproperty
  a_pdown_guard: assert property (p_pdown_guard) else $error("power-down outside standby");

  property p_duty_wake;
    @(posedge sys_clk) disable iff (!rst_n)
    q.st == ST_LOW_POWER_HOLD_STATE && q.cfg.op_mode == MODE_DUTY && tick && !wr_cfg
      && q.cnt == low_power_hold_state_last(q.cfg) |=> q.st == ST_CONV && q.cnt == '0;
  endproperty
  a_duty_wake: assert property (p_duty_wake) else $error("duty standby length wrong");

  property p_sync_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    q.st == ST_IDLE && q.cfg.op_mode == MODE_SYNC_IDLE && sync_fall && !wr_cfg
      |=> q.st == ST_CONV ##1 converting;
  endproperty
  a_sync_idle: assert property (p_sync_idle) else $error("sync edge did not restart");

  property p_idle_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    q.st == ST_IDLE |=> modulator_reset && !converting;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("modulator not held in idle");

  property p_sync_low_power_hold_state;
    @(posedge sys_clk) disable iff (!rst_n)
    conv_end && !wr_cfg && q.cfg.op_mode == MODE_SYNC_LOW_POWER_HOLD_STATE
      |=> q.st == ST_LOW_POWER_HOLD_STATE ##1 low_power_hold_state;
  endproperty
  a_sync_low_power_hold_state: assert property (p_sync_low_power_hold_state) else $error("no standby after sequence");

  property p_pdown_ok;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cfg && wcfg.op_mode == MODE_PDOWN && q.st == ST_LOW_POWER_HOLD_STATE
      |=> q.st == ST_PDOWN ##1 power_down;
  endproperty
  a_pdown_ok: assert property (p_pdown_ok) else $error("no power-down from standby");

  // outside duty cycling only a sync edge or a write may end standby
  property p_ratio_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
    q.st == ST_LOW_POWER_HOLD_STATE && q.cfg.op_mode != MODE_DUTY && !sync_fall && !wr_cfg
      |=> q.st == ST_LOW_POWER_HOLD_STATE;
  endproperty
  a_ratio_ignored: assert property (p_ratio_ignored) else $error("standby left early");

  property p_div_skip;
    @(posedge sys_clk) disable iff (!rst_n)
    q.cfg.clk_sel == CLK_EXT_DIV2 && !q.div_q |-> !tick;
  endproperty
  a_div_skip: assert property (p_div_skip) else $error("divided clock ticked early");

  property p_reserved_keep;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cfg && !mode_ok(wcfg.op_mode) && !cal_end
      |=> q.cfg.op_mode == $past(q.cfg.op_mode);
  endproperty
  a_reserved_keep: assert property (p_reserved_keep) else $error("reserved code changed mode");

  property p_ref_level;
    @(posedge sys_clk) disable iff (!rst_n)
    q.cfg.int_ref_en
      |=> ref_enable && reference_level_select == $past(q.cfg.reference_level_select);
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reference level not followed");

endmodule // adc_mode_ctl

// ==== adc_ctl_pkg.sv ====
package adc_ctl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 20;

  // register map
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;

  // operating mode codes
  localparam logic [3:0] MODE_SINGLE = 4'h0;
  localparam logic [3:0] MODE_LOW_POWER_HOLD_STATE = 4'h1;
  localparam logic [3:0] MODE_PDOWN = 4'h2;
  localparam logic [3:0] MODE_IDLE = 4'h3;
  localparam logic [3:0] MODE_CAL = 4'h4;
  localparam logic [3:0] MODE_CONT = 4'h5;
  localparam logic [3:0] MODE_DUTY = 4'h9;
  localparam logic [3:0] MODE_SYNC_IDLE = 4'ha;
  localparam logic [3:0] MODE_SYNC_LOW_POWER_HOLD_STATE = 4'hb;

  // main clock source codes
  localparam logic [1:0] CLK_INT_OFF = 2'h0;
  localparam logic [1:0] CLK_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  localparam logic [1:0] CLK_EXT_DIV2 = 2'h3;

  // standby length as a multiple of the active time
  localparam int LOW_POWER_HOLD_STATE_MULT_QUARTER = 3;
  localparam int LOW_POWER_HOLD_STATE_MULT_SIXTEENTH = 15;

  typedef struct packed {
    logic [6:0] pad;
    logic int_ref_en;
    logic reference_level_select;
    logic active_fraction_select;
    logic [3:0] op_mode;
    logic [1:0] clk_sel;
  } cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CONV = 5'h02,
    ST_LOW_POWER_HOLD_STATE = 5'h04,
    ST_PDOWN = 5'h08,
    ST_CAL = 5'h10
  } ctl_state_t;

  typedef struct packed {
    cfg_t cfg;
    ctl_state_t st;
    logic [CNT_W-1:0] cnt;
    logic osc_q;
    logic pin_q;
    logic sync_q;
    logic div_q;
    logic [DATA_W-1:0] rd_data;
    logic ref_on;
    logic ref_lvl;
    logic clk_out;
    logic clk_oe;
    logic mod_rst;
    logic conv;
    logic hold;
    logic pdown;
    logic done;
  } state_t;

  localparam state_t STATE_RESET = '{
    cfg: cfg_t'(CFG_RESET), st: ST_IDLE, cnt: '0, osc_q: 1'b0, pin_q: 1'b0,
    sync_q: 1'b1, div_q: 1'b0, rd_data: '0, ref_on: 1'b0, ref_lvl: 1'b0,
    clk_out: 1'b0, clk_oe: 1'b0, mod_rst: 1'b1, conv: 1'b0, hold: 1'b0,
    pdown: 1'b0, done: 1'b0};

endpackage

// ==== adc_mode_and_clock_control_tb_top.sv ====
`timescale 1ns/1ps
module adc_mode_and_clock_control_tb_top;
  import adc_ctl_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rd_data;
  logic [7:0] osc_div = 8'h00;
  logic sync_n = 1'b1;
  logic counting = 1'b0;
  logic use_pin = 1'b0;
  logic pin_fast = 1'b0;
  logic osc_clk, clk_pin_in, tick, clk_pin_out, clk_pin_oe, ref_enable, reference_level_select;
  logic modulator_reset, converting, low_power_hold_state, power_down, seq_done;
  int err_count = 0;
  int samples_checked = 0;
  int n_conv, n_low_power_hold_state, n_done;
  // pin runs at base rate for select 10, double for 11; oscillator stops so only the pin can tick
  assign osc_clk = osc_div[3] & ~use_pin;
  assign clk_pin_in = use_pin & (pin_fast ? osc_div[2] : osc_div[3]);
  assign tick = (use_pin && pin_fast) ? (osc_div[2:0] == 3'h3) : (osc_div[3:0] == 4'h7);

  adc_mode_ctl #(.CONV_TICKS(2), .CAL_TICKS(2)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .req(req), .rd_data(rd_data), .osc_clk(osc_clk), .clk_pin_in(clk_pin_in),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .sync_n(sync_n),
    .ref_enable(ref_enable), .reference_level_select(reference_level_select),
    .modulator_reset(modulator_reset), .converting(converting),
    .low_power_hold_state(low_power_hold_state), .power_down(power_down), .seq_done(seq_done));

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) osc_div <= osc_div + 8'h01;
  always @(posedge sys_clk) begin
    n_done += int'(seq_done === 1'b1);
    if (counting && tick) begin
      n_conv += int'(converting === 1'b1);
      n_low_power_hold_state += int'(low_power_hold_state === 1'b1);
    end
  end

  function automatic logic [15:0] mk(logic en, logic lvl, logic rat, logic [3:0] m, logic [1:0] s);
    return {7'h00, en, lvl, rat, m, s};
  endfunction

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 chk(name, rd_data, exp);
    @(posedge sys_clk);
    #1 chk("rd_data_after", rd_data, 16'h0000);
  endtask

  task automatic wait_conv(input logic v);
    for (int i = 0; i < 2000 && converting !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("converting", {15'h0000, converting}, {15'h0000, v});
  endtask

  task automatic t_reset;
    rdchk("cfg_reset", CFG_ADDR, CFG_RESET);
    rdchk("status_reset", STATUS_ADDR, 16'h0001);
    rdchk("unmapped", 8'h07, 16'h0000);
    chk("ref_reset", {15'h0000, ref_enable}, 16'h0000);
    chk("oe_reset", {15'h0000, clk_pin_oe}, 16'h0000);
  endtask

  task automatic t_ref;
    wr(CFG_ADDR, mk(1'b1, 1'b1, 1'b0, MODE_IDLE, CLK_INT_OFF));
    chk("ref_on", {14'h0000, ref_enable, reference_level_select}, 16'h0003);
    wr(CFG_ADDR, mk(1'b0, 1'b1, 1'b0, MODE_IDLE, CLK_INT_OFF));
    chk("ref_off", {14'h0000, ref_enable, reference_level_select}, 16'h0000);
    rdchk("cfg_back", CFG_ADDR, mk(1'b0, 1'b1, 1'b0, MODE_IDLE, CLK_INT_OFF));
    chk("idle_reset", {15'h0000, modulator_reset}, 16'h0001);
  endtask

  task automatic t_clk(input logic [1:0] s, input logic oe);
    logic seen_hi;
    logic seen_lo;
    seen_hi = 1'b0;
    seen_lo = 1'b0;
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_IDLE, s));
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      seen_hi |= (clk_pin_out === 1'b1);
      seen_lo |= (clk_pin_out === 1'b0);
    end
    chk("pin_oe", {15'h0000, clk_pin_oe}, {15'h0000, oe});
    chk("pin_toggle", {14'h0000, seen_hi, seen_lo}, {14'h0000, oe, 1'b1});
  endtask

  task automatic t_duty(input logic [1:0] s, input logic rat, input logic pin, input int ec,
    input int es);
    @(posedge sys_clk) begin
      use_pin <= pin;
      pin_fast <= (s == CLK_EXT_DIV2);
    end
    wr(CFG_ADDR, mk(1'b0, 1'b0, rat, MODE_DUTY, s));
    wait_conv(1'b0);
    wait_conv(1'b1);
    n_conv = 0;
    n_low_power_hold_state = 0;
    n_done = 0;
    counting = 1'b1;
    wait_conv(1'b0);
    wait_conv(1'b1);
    counting = 1'b0;
    chk("active_ticks", 16'(n_conv), 16'(ec));
    chk("standby_ticks", 16'(n_low_power_hold_state), 16'(es));
    chk("duty_done_pulses", 16'(n_done), 16'h0001);
  endtask

  task automatic t_sync(input logic [3:0] m, input logic [15:0] st);
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b1, m, CLK_INT_OFF));
    wait_conv(1'b1);
    n_done = 0;
    wait_conv(1'b0);
    chk("seq_done_pulses", 16'(n_done), 16'h0001);
    rdchk("after_seq", STATUS_ADDR, st);
    chk("hold_reset", {15'h0000, modulator_reset}, 16'h0001);
    repeat (60) @(posedge sys_clk);
    #1 chk("waits_sync", {15'h0000, converting}, 16'h0000);
    @(posedge sys_clk) sync_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    sync_n <= 1'b1;
    wait_conv(1'b1);
    wait_conv(1'b0);
  endtask

  task automatic t_modes;
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_PDOWN, CLK_INT_OFF));
    rdchk("pdown_state", STATUS_ADDR, 16'h0008);
    chk("pdown_pin", {15'h0000, power_down}, 16'h0001);
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_IDLE, CLK_INT_OFF));
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_PDOWN, CLK_INT_OFF));
    rdchk("pdown_guard", CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_CONT, CLK_INT_OFF));
    chk("guard_conv", {14'h0000, converting, power_down}, 16'h0002);
    wr(CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_CAL, CLK_INT_OFF));
    rdchk("cal_state", STATUS_ADDR, 16'h0010);
    repeat (100) @(posedge sys_clk);
    rdchk("cal_to_idle", CFG_ADDR, mk(1'b0, 1'b0, 1'b0, MODE_IDLE, CLK_INT_OFF));
    rdchk("cal_idle_st", STATUS_ADDR, 16'h0001);
    wr(CFG_ADDR, mk(1'b1, 1'b0, 1'b0, 4'hc, CLK_INT_OFF));
    rdchk("reserved", CFG_ADDR, mk(1'b1, 1'b0, 1'b0, MODE_IDLE, CLK_INT_OFF));
    rdchk("reserved_st", STATUS_ADDR, 16'h0001);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_ref();
    t_clk(CLK_INT_OUT, 1'b1);
    t_clk(CLK_INT_OFF, 1'b0);
    t_duty(CLK_INT_OFF, 1'b0, 1'b0, 2, 6);
    t_duty(CLK_INT_OUT, 1'b1, 1'b0, 2, 30);
    t_duty(CLK_EXT, 1'b0, 1'b1, 2, 6);
    t_duty(CLK_EXT_DIV2, 1'b1, 1'b1, 4, 60);
    @(posedge sys_clk) use_pin <= 1'b0;
    t_sync(MODE_SYNC_IDLE, 16'h0001);
    t_sync(MODE_SYNC_LOW_POWER_HOLD_STATE, 16'h0004);
    t_modes();
    end_sim();
  end

  // whole run is near 3.2k cycles; allow well over twice that
  initial begin
    #300000;
    err_count++;
    end_sim();
  end
endmodule // adc_mode_and_clock_control_tb_top
